// ### inc/dsd_regs.svh
// Register map, field positions, reset values and timing counts
`ifndef DSD_REGS_SVH
`define DSD_REGS_SVH
`define DSD_CTRL_OFF 12'h000
`define DSD_EVT_OFF 12'h004
`define DSD_SETPT_OFF 12'h008
`define DSD_STAT_OFF 12'h00c
`define DSD_CTRL_TENTHS 0
`define DSD_CTRL_COAST 1
`define DSD_CTRL_SRC_LSB 2
`define DSD_CTRL_OEM 6
`define DSD_CTRL_OEM_BAD 7
`define DSD_CTRL_USER_BAD 8
`define DSD_CTRL_RESET 9'h000
`define DSD_EVT_INVALID 0
`define DSD_EVT_OEM_EDIT 1
`define DSD_EVT_OEM_RESET 2
`define DSD_EVT_PWRUP 3
`define DSD_EVT_FACTORY 4
`define DSD_EVT_MANUAL 5
`define DSD_SETPT_DEFAULT 11'h0c8
`define DSD_FREQ_MAX 11'h4b0
`define DSD_FREQ_HUND 11'h3e8
`define DSD_FAIL_MAX 2'h3
`define DSD_CLK_NS 10
`define DSD_TICK_MS 1
`define DSD_TENTH_MS 16'h03e8
`define DSD_VIEW_MS 16'h0bb8
`define DSD_FLASH_MS 16'h07d0
`define DSD_MSG_MS 16'h07d0
`define DSD_REPEAT_MS 16'h012c
`define DSD_BLINK_MS 10'h0fa
`define DSD_CYCLE_MS 10'h3e8
`define DSD_CL_TRIP_MS 16'hea60
`define DSD_G_DASH 5'h0a
`define DSD_G_BLANK 5'h0b
`define DSD_G_C 5'h0c
`define DSD_G_P 5'h0d
`define DSD_G_E 5'h0e
`define DSD_G_I 5'h0f
`define DSD_G_U 5'h10
`define DSD_G_J 5'h11
`define DSD_G_G 5'h12
`define DSD_G_O 5'h13
`define DSD_G_B 5'h14
`define DSD_G_R 5'h15
`define DSD_G_L 5'h16
`define DSD_G_S 5'h17
`define DSD_G_F 5'h18
`endif

// ### inc/dsd_pkg.sv
// Types of the speed and status display block
package dsd_pkg;
	typedef enum logic [3:0] {
		V_IDLE = 4'b0001,
		V_WHOLE = 4'b0010,
		V_TENTH = 4'b0100,
		V_EDIT = 4'b1000
	} dsd_view_t;
	typedef struct packed {
		logic [1:0] up_sy;
		logic [1:0] dn_sy;
		logic up_q;
		logic dn_q;
		logic [8:0] ctrl;
		logic [10:0] setpt;
		dsd_view_t view;
		logic [15:0] view_tmr;
		logic [16:0] tick_cnt;
		logic [9:0] blink_cnt;
		logic [15:0] hold_tmr;
		logic held;
		logic [3:0] flash_src;
		logic [15:0] flash_tmr;
		logic [9:0] msg;
		logic [15:0] msg_tmr;
		logic [3:0] src_prev;
		logic [1:0] fail_cnt;
		logic lockout;
		logic [15:0] cl_tmr;
		logic overload;
		logic [4:0] gl_l;
		logic [4:0] gl_r;
		logic dp_l;
		logic dp_r;
		logic decel_hold;
	} dsd_state_t;
endpackage : dsd_pkg

// ### core/dsd_display.sv
// Front-panel speed and status display with up/down keypad editing
//
// Notes on behaviour
// - Stop: first press lights left point and shows setpoint whole hertz
// - Factory reset puts the setpoint at 20.0 Hz
// - Stop: second press shows tenths briefly, then whole hertz again
// - Tenths editing: held key steps tenths to whole hertz, then 1 Hz
// - Whole-hertz editing: keypad steps are 1 Hz, saturating at 0 and 120 Hz
// - Run: show whole hertz of output frequency, left point dark
// - Run: single press shows tenths with left point lit, setpoint kept
// - Left point blinks while output ramps toward a viewed setpoint
// - Ramp stop: shown frequency falls, then two dashes once stopped
// - DC braking stop: braking message during braking, then two dashes
// - Coast stop without braking: two dashes at once
// - Above 99.9 Hz alternate hundreds mark and tens-ones; max 120 Hz
// - Source change while running flashes the new source code
// - Non-keypad source: key press keeps setpoint, flashes source code
// - Distinct two-character code for every speed source
// - Current limit shows its message; too long trips overload
// - Rejected entry shows the invalid-entry message
// - OEM mode refuses default edits and shows the blocked message
// - Corrupt data message: bad OEM data at OEM reset, or all at power-up
// - Three failed restarts show lockout and need a manual reset
// - Restart-pending message blinks between restart attempts
// - Bus overvoltage threat pauses deceleration and lights both points
`timescale 1ns/100ps
`include "dsd_regs.svh"

module dsd_display #(
	parameter int TICK_CYCLES = `DSD_TICK_MS * 1000000 / `DSD_CLK_NS,
	parameter logic [15:0] CL_TRIP_MS = `DSD_CL_TRIP_MS
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [11:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic KEY_UP,
	input wire logic KEY_DN,
	input wire logic DRV_RUN,
	input wire logic [10:0] DRV_FREQ,
	input wire logic DRV_BRAKE,
	input wire logic DRV_DECEL,
	input wire logic BUS_HIGH,
	input wire logic CUR_LIMIT,
	input wire logic RESTART_FAIL,
	input wire logic RESTART_WAIT,
	output logic [4:0] GLYPH_L,
	output logic [4:0] GLYPH_R,
	output logic DP_L,
	output logic DP_R,
	output logic [10:0] SETPOINT,
	output logic RUN_INHIBIT,
	output logic DECEL_HOLD,
	output logic OVERLOAD_TRIP
);
	import dsd_pkg::*;

	dsd_state_t st_ff;
	dsd_state_t nxt_st;

	function automatic logic [9:0] pair(input logic [4:0] a,
		input logic [4:0] b);
		pair = {a, b};
	endfunction : pair

	function automatic logic [4:0] digit(input logic [6:0] v);
		digit = 5'(v % 7'h0a);
	endfunction : digit

	// Whole hertz of a tenths value; hundreds shown in two alternating parts
	function automatic logic [9:0] disp_val(input logic [10:0] v,
		input logic alt);
		logic [6:0] w;
		w = 7'(v / 11'h00a);
		if (v >= `DSD_FREQ_HUND) begin
			if (alt)
				disp_val = pair(5'h01, `DSD_G_DASH);
			else
				disp_val = pair(digit(7'((w - 7'h64) / 7'h0a)),
					digit(w - 7'h64));
		end else begin
			disp_val = pair(digit(7'(w / 7'h0a)), digit(w));
		end
	endfunction : disp_val

	function automatic logic [9:0] src_msg(input logic [3:0] s);
		case (s)
			4'h0: src_msg = pair(`DSD_G_C, `DSD_G_P);
			4'h1: src_msg = pair(`DSD_G_E, `DSD_G_I);
			4'h2: src_msg = pair(`DSD_G_E, `DSD_G_U);
			4'h3: src_msg = pair(`DSD_G_J, `DSD_G_G);
			4'h4: src_msg = pair(`DSD_G_O, `DSD_G_P);
			default: src_msg = pair(`DSD_G_P, 5'(s - 4'h4));
		endcase
	endfunction : src_msg

	function automatic logic [10:0] step(input logic [10:0] sp,
		input logic up, input logic [10:0] amt);
		if (up)
			step = (sp + amt > `DSD_FREQ_MAX) ? `DSD_FREQ_MAX : 11'(sp + amt);
		else
			step = (sp < amt) ? 11'h000 : 11'(sp - amt);
	endfunction : step

	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [3:0] src;
	logic tick;
	logic up_lvl;
	logic dn_lvl;
	logic press;
	logic press_up;
	logic keypad;
	logic alt;
	logic blink;
	logic fresh_view;
	logic [10:0] amt;
	logic [9:0] show;
	logic dp_show;

	assign wr_en = PSEL && PENABLE && PWRITE;
	assign rd_en = PSEL && !PWRITE;
	assign addr_ok = PADDR == `DSD_CTRL_OFF || PADDR == `DSD_EVT_OFF ||
		PADDR == `DSD_SETPT_OFF || PADDR == `DSD_STAT_OFF;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !addr_ok;
	assign src = st_ff.ctrl[`DSD_CTRL_SRC_LSB +: 4];
	assign tick = st_ff.tick_cnt == 17'(TICK_CYCLES - 1);
	assign up_lvl = st_ff.up_sy[1];
	assign dn_lvl = st_ff.dn_sy[1];
	// Both keys together count as no key
	assign press = (up_lvl && !st_ff.up_q && !dn_lvl) ||
		(dn_lvl && !st_ff.dn_q && !up_lvl);
	assign press_up = up_lvl;
	assign keypad = src == 4'h0;
	assign alt = st_ff.blink_cnt < (`DSD_CYCLE_MS >> 1);
	assign blink = st_ff.blink_cnt < `DSD_BLINK_MS ||
		(st_ff.blink_cnt >= (`DSD_BLINK_MS << 1) &&
		st_ff.blink_cnt < 10'(`DSD_BLINK_MS * 3));

	always_comb begin
		PRDATA = 32'h0000_0000;
		if (rd_en) begin
			case (PADDR)
				`DSD_CTRL_OFF: PRDATA = {23'h000000, st_ff.ctrl};
				`DSD_SETPT_OFF: PRDATA = {21'h000000, st_ff.setpt};
				`DSD_STAT_OFF: PRDATA = {20'h00000, st_ff.overload,
					st_ff.lockout, st_ff.gl_r, st_ff.gl_l};
				default: PRDATA = 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		nxt_st = st_ff;
		fresh_view = 1'b0;
		show = pair(`DSD_G_DASH, `DSD_G_DASH);
		dp_show = 1'b0;
		// Keys come from the panel pins, so they are synchronised first
		nxt_st.up_sy = {st_ff.up_sy[0], KEY_UP};
		nxt_st.dn_sy = {st_ff.dn_sy[0], KEY_DN};
		nxt_st.up_q = up_lvl;
		nxt_st.dn_q = dn_lvl;
		nxt_st.tick_cnt = tick ? 17'h00000 : 17'(st_ff.tick_cnt + 17'h1);
		if (tick) begin
			nxt_st.blink_cnt = (st_ff.blink_cnt == `DSD_CYCLE_MS - 10'h1) ?
				10'h000 : 10'(st_ff.blink_cnt + 10'h1);
			if (st_ff.view_tmr != 16'h0000)
				nxt_st.view_tmr = 16'(st_ff.view_tmr - 16'h1);
			if (st_ff.flash_tmr != 16'h0000)
				nxt_st.flash_tmr = 16'(st_ff.flash_tmr - 16'h1);
			if (st_ff.msg_tmr != 16'h0000)
				nxt_st.msg_tmr = 16'(st_ff.msg_tmr - 16'h1);
		end
		if (wr_en && PADDR == `DSD_CTRL_OFF)
			nxt_st.ctrl = PWDATA[8:0];

		// Timed view steps back; tenths peek in stop returns to whole hertz
		if (tick && st_ff.view_tmr == 16'h0001) begin
			if (st_ff.view == V_TENTH && !DRV_RUN) begin
				// Back to whole hertz, now ready to step on the next press
				nxt_st.view = V_EDIT;
				nxt_st.view_tmr = `DSD_VIEW_MS;
			end else begin
				nxt_st.view = V_IDLE;
			end
		end

		amt = st_ff.ctrl[`DSD_CTRL_TENTHS] ? 11'h001 : 11'h00a;
		if (press && !keypad) begin
			nxt_st.flash_src = src;
			nxt_st.flash_tmr = `DSD_FLASH_MS;
		end else if (press) begin
			nxt_st.hold_tmr = 16'h0000;
			nxt_st.held = 1'b0;
			case (st_ff.view)
				V_IDLE: begin
					nxt_st.view = DRV_RUN ? V_TENTH : V_WHOLE;
					nxt_st.view_tmr = DRV_RUN ? `DSD_TENTH_MS : `DSD_VIEW_MS;
				end
				V_WHOLE: begin
					nxt_st.view = V_TENTH;
					nxt_st.view_tmr = `DSD_TENTH_MS;
				end
				V_TENTH, V_EDIT: begin
					nxt_st.view = V_EDIT;
					nxt_st.view_tmr = `DSD_VIEW_MS;
					nxt_st.setpt = step(st_ff.setpt, press_up, amt);
				end
				default: nxt_st.view = V_IDLE;
			endcase
		end else if ((up_lvl ^ dn_lvl) && keypad && st_ff.view == V_EDIT) begin
			// Auto-repeat while held; tenths only up to the next whole hertz
			if (tick)
				nxt_st.hold_tmr = 16'(st_ff.hold_tmr + 16'h1);
			if (tick && st_ff.hold_tmr == `DSD_REPEAT_MS - 16'h1) begin
				nxt_st.hold_tmr = 16'h0000;
				nxt_st.held = 1'b1;
				nxt_st.view_tmr = `DSD_VIEW_MS;
				if (st_ff.ctrl[`DSD_CTRL_TENTHS] && st_ff.held &&
					st_ff.setpt % 11'h00a == 11'h000)
					amt = 11'h00a;
				nxt_st.setpt = step(st_ff.setpt, press_up, amt);
			end
		end

		// Source change while running flashes the new source
		nxt_st.src_prev = src;
		if (DRV_RUN && src != st_ff.src_prev) begin
			nxt_st.flash_src = src;
			nxt_st.flash_tmr = `DSD_FLASH_MS;
		end

		if (wr_en && PADDR == `DSD_EVT_OFF) begin
			if (PWDATA[`DSD_EVT_FACTORY])
				nxt_st.setpt = `DSD_SETPT_DEFAULT;
			if (PWDATA[`DSD_EVT_INVALID]) begin
				nxt_st.msg = pair(`DSD_G_E, `DSD_G_R);
				nxt_st.msg_tmr = `DSD_MSG_MS;
			end
			if (PWDATA[`DSD_EVT_OEM_EDIT] && st_ff.ctrl[`DSD_CTRL_OEM]) begin
				nxt_st.msg = pair(`DSD_G_G, `DSD_G_E);
				nxt_st.msg_tmr = `DSD_MSG_MS;
			end
			if ((PWDATA[`DSD_EVT_OEM_RESET] && st_ff.ctrl[`DSD_CTRL_OEM_BAD]) ||
				(PWDATA[`DSD_EVT_PWRUP] && st_ff.ctrl[`DSD_CTRL_OEM_BAD] &&
				st_ff.ctrl[`DSD_CTRL_USER_BAD])) begin
				nxt_st.msg = pair(`DSD_G_G, `DSD_G_F);
				nxt_st.msg_tmr = `DSD_MSG_MS;
			end
		end

		// Failed restarts count toward lockout; a failure beats the clear unless already locked out
		if (wr_en && PADDR == `DSD_EVT_OFF && PWDATA[`DSD_EVT_MANUAL]) begin
			nxt_st.fail_cnt = 2'h0;
			nxt_st.lockout = 1'b0;
			nxt_st.overload = 1'b0;
		end
		if (RESTART_FAIL && !st_ff.lockout) begin
			nxt_st.fail_cnt = 2'(st_ff.fail_cnt + 2'h1);
			if (st_ff.fail_cnt == `DSD_FAIL_MAX - 2'h1)
				nxt_st.lockout = 1'b1;
		end

		if (!CUR_LIMIT) begin
			nxt_st.cl_tmr = 16'h0000;
		end else if (tick && st_ff.cl_tmr != CL_TRIP_MS) begin
			nxt_st.cl_tmr = 16'(st_ff.cl_tmr + 16'h1);
		end else if (st_ff.cl_tmr == CL_TRIP_MS) begin
			nxt_st.overload = 1'b1;
		end
		nxt_st.decel_hold = DRV_DECEL && BUS_HIGH;

		// Display priority: flashes and faults over speed readouts
		if (st_ff.flash_tmr != 16'h0000) begin
			show = blink ? src_msg(st_ff.flash_src) :
				pair(`DSD_G_BLANK, `DSD_G_BLANK);
		end else if (st_ff.lockout) begin
			show = pair(`DSD_G_L, `DSD_G_C);
		end else if (RESTART_WAIT) begin
			show = blink ? pair(`DSD_G_S, `DSD_G_P) :
				pair(`DSD_G_BLANK, `DSD_G_BLANK);
		end else if (CUR_LIMIT) begin
			show = pair(`DSD_G_C, `DSD_G_L);
		end else if (st_ff.msg_tmr != 16'h0000) begin
			show = st_ff.msg;
		end else if (DRV_BRAKE) begin
			show = pair(`DSD_G_B, `DSD_G_R);
		end else if (st_ff.view == V_TENTH) begin
			show = pair(`DSD_G_BLANK,
				5'((DRV_RUN ? DRV_FREQ : st_ff.setpt) % 11'h00a));
			dp_show = 1'b1;
		end else if (st_ff.view != V_IDLE) begin
			show = disp_val(st_ff.setpt, alt);
			fresh_view = DRV_RUN && DRV_FREQ != st_ff.setpt;
			dp_show = fresh_view ? blink : 1'b1;
		end else if (DRV_RUN) begin
			show = disp_val(DRV_FREQ, alt);
		end else if (!st_ff.ctrl[`DSD_CTRL_COAST] && DRV_FREQ != 11'h000) begin
			show = disp_val(DRV_FREQ, alt);
		end else begin
			show = pair(`DSD_G_DASH, `DSD_G_DASH);
		end
		nxt_st.gl_l = show[9:5];
		nxt_st.gl_r = show[4:0];
		nxt_st.dp_l = dp_show || (DRV_DECEL && BUS_HIGH);
		nxt_st.dp_r = DRV_DECEL && BUS_HIGH;
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			st_ff <= '0;
			st_ff.view <= V_IDLE;
			st_ff.ctrl <= `DSD_CTRL_RESET;
			st_ff.setpt <= `DSD_SETPT_DEFAULT;
			st_ff.gl_l <= `DSD_G_DASH;
			st_ff.gl_r <= `DSD_G_DASH;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign GLYPH_L = st_ff.gl_l;
	assign GLYPH_R = st_ff.gl_r;
	assign DP_L = st_ff.dp_l;
	assign DP_R = st_ff.dp_r;
	assign SETPOINT = st_ff.setpt;
	assign RUN_INHIBIT = st_ff.lockout;
	assign DECEL_HOLD = st_ff.decel_hold;
	assign OVERLOAD_TRIP = st_ff.overload;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	logic quiet;
	logic fact_wr;
	assign quiet = st_ff.flash_tmr == 16'h0000 && !st_ff.lockout &&
		!RESTART_WAIT && !CUR_LIMIT && st_ff.msg_tmr == 16'h0000;
	assign fact_wr = wr_en && PADDR == `DSD_EVT_OFF &&
		PWDATA[`DSD_EVT_FACTORY];

	sequence stop_press_s;
		!DRV_RUN && keypad && press && st_ff.view == V_IDLE && !fact_wr;
	endsequence
	sequence fail_three_s;
		RESTART_FAIL && st_ff.fail_cnt == 2'h2 && !st_ff.lockout;
	endsequence

	stop_first_view_a: assert property (
		stop_press_s |=> st_ff.view == V_WHOLE && $stable(st_ff.setpt)
		##1 (st_ff.dp_l || !quiet || DRV_BRAKE || DRV_RUN))
		else $error("stop first press did not show setpoint");
	factory_default_a: assert property (
		fact_wr |=> st_ff.setpt == 11'h0c8)
		else $error("factory reset setpoint wrong");
	whole_step_a: assert property (
		!$past(st_ff.ctrl[`DSD_CTRL_TENTHS]) && !$past(fact_wr) &&
		$changed(st_ff.setpt) |-> st_ff.setpt == $past(st_ff.setpt) + 11'h00a
		|| st_ff.setpt + 11'h00a == $past(st_ff.setpt) ||
		st_ff.setpt == 11'h000 || st_ff.setpt == 11'h4b0)
		else $error("whole hertz step not one hertz");
	run_press_keep_a: assert property (
		DRV_RUN && keypad && press && st_ff.view == V_IDLE && !fact_wr
		|=> st_ff.view == V_TENTH && $stable(st_ff.setpt))
		else $error("run press changed setpoint");
	coast_dashes_a: assert property (
		!DRV_RUN && !DRV_BRAKE && quiet && st_ff.view == V_IDLE &&
		st_ff.ctrl[`DSD_CTRL_COAST] |=> st_ff.gl_l == 5'h0a &&
		st_ff.gl_r == 5'h0a)
		else $error("coast stop did not show dashes");
	brake_msg_a: assert property (
		DRV_BRAKE && quiet |=> st_ff.gl_l == 5'h14 && st_ff.gl_r == 5'h15)
		else $error("braking message missing");
	src_lock_a: assert property (
		press && !keypad && !fact_wr |=> $stable(st_ff.setpt) &&
		st_ff.flash_tmr == 16'h07d0 ##1 (!$past(blink) ||
		{st_ff.gl_l, st_ff.gl_r} == src_msg($past(st_ff.flash_src))))
		else $error("foreign source press not refused");
	lockout_seq_a: assert property (
		fail_three_s |=> st_ff.lockout ##1 RUN_INHIBIT &&
		(st_ff.gl_l == 5'h16 || $past(st_ff.flash_tmr) != 16'h0000))
		else $error("lockout not entered after three failures");
	decel_dp_a: assert property (
		DRV_DECEL && BUS_HIGH |=> DECEL_HOLD && DP_L && DP_R)
		else $error("decel override not shown");
endmodule : dsd_display

// ### tb/dsd_operator.sv
// Operator model pressing the panel up and down keys
`timescale 1ns/100ps
module dsd_operator (
	input wire logic CLK,
	input wire logic want_up,
	input wire logic want_dn,
	output logic KEY_UP,
	output logic KEY_DN
);
	// A person is never faster than a clock, so keys lag the wish
	always_ff @(posedge CLK) begin
		KEY_UP <= want_up;
		KEY_DN <= want_dn;
	end
endmodule : dsd_operator

// ### tb/testbench.sv
// Self-checking bench of the speed and status display
`timescale 1ns/100ps
`include "dsd_regs.svh"
module testbench;
	logic clk, nrst, psel, penable, pwrite, want_up, want_dn, err;
	logic key_up, key_dn, run, brake, decel, bus_hi, cur_lim;
	logic rs_fail, rs_wait, pready, pslverr, dp_l, dp_r;
	logic inhibit, dhold, ovl;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [10:0] freq, setpt;
	logic [4:0] gl, gr;
	logic [4:0] src_l [12];
	logic [4:0] src_r [12];
	int miscompares, checks, cyc;

	dsd_display #(.TICK_CYCLES(10), .CL_TRIP_MS(16'h0005)) dsd_display_inst (
		.CLK(clk), .NRST(nrst), .PADDR(paddr), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.KEY_UP(key_up), .KEY_DN(key_dn), .DRV_RUN(run),
		.DRV_FREQ(freq), .DRV_BRAKE(brake), .DRV_DECEL(decel),
		.BUS_HIGH(bus_hi), .CUR_LIMIT(cur_lim), .RESTART_FAIL(rs_fail),
		.RESTART_WAIT(rs_wait), .GLYPH_L(gl), .GLYPH_R(gr), .DP_L(dp_l),
		.DP_R(dp_r), .SETPOINT(setpt), .RUN_INHIBIT(inhibit),
		.DECEL_HOLD(dhold), .OVERLOAD_TRIP(ovl));
	dsd_operator dsd_operator_inst (.CLK(clk), .want_up(want_up),
		.want_dn(want_dn), .KEY_UP(key_up), .KEY_DN(key_dn));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	// Ceiling sits above the longest display timeouts strung together
	always @(posedge clk) begin
		cyc++;
		if (cyc == 99000) begin
			miscompares++;
			print_verdict();
		end
	end

	task cycles(input int n);
		repeat (n) @(posedge clk);
	endtask : cycles

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wait_gl(input logic [4:0] l, input logic [4:0] r, input int lim);
		int n;
		n = 0;
		while (!(gl === l && gr === r) && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk({gl, gr}, {l, r});
	endtask : wait_gl

	task wait_dp(input logic v, input int lim);
		int n;
		n = 0;
		while (dp_l !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(dp_l, v);
	endtask : wait_dp

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task evt(input int b);
		apb(1'b1, `DSD_EVT_OFF, 32'h1 << b);
		cycles(3);
	endtask : evt

	task press(input logic up, input int hold);
		want_up <= up;
		want_dn <= !up;
		cycles(hold);
		want_up <= 1'b0;
		want_dn <= 1'b0;
		cycles(10);
	endtask : press

	task done(input string s);
		$display("test %s done, checks %0d", s, checks);
	endtask : done

	task t_regs;
		chk({gl, gr, dp_l, dp_r}, {`DSD_G_DASH, `DSD_G_DASH, 2'b00});
		chk(setpt, 11'h0c8);
		apb(1'b1, `DSD_CTRL_OFF, 32'h1ff);
		apb(1'b0, `DSD_CTRL_OFF, 32'h0);
		chk(rd, 32'h1ff);
		apb(1'b1, `DSD_CTRL_OFF, 32'h0);
		apb(1'b1, `DSD_SETPT_OFF, 32'h55);
		apb(1'b0, `DSD_SETPT_OFF, 32'h0);
		chk(rd, 32'hc8);
		apb(1'b0, 12'h010, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		done("registers");
	endtask : t_regs

	task t_stop_keys;
		press(1'b1, 8);
		chk({gl, gr, dp_l, setpt}, {10'h040, 1'b1, 11'h0c8});
		press(1'b0, 8);
		chk({gl !== 5'h02, dp_l, setpt}, {2'b11, 11'h0c8});
		wait_gl(5'h02, 5'h00, 12000);
		press(1'b1, 8);
		chk(setpt, 11'h0d2);
		apb(1'b1, `DSD_CTRL_OFF, 32'h1);
		for (int i = 0; i < 8; i++) begin
			press(1'b1, 8);
		end
		chk(setpt, 11'h0da);
		press(1'b1, 7500);
		chk(setpt, 11'h0e6);
		done("stop keypad");
	endtask : t_stop_keys

	task t_run;
		freq <= 11'h1c5;
		run <= 1'b1;
		wait_dp(1'b0, 3000);
		wait_dp(1'b1, 3000);
		wait_gl(5'h04, 5'h05, 32000);
		chk(dp_l, 1'b0);
		press(1'b1, 8);
		chk({dp_l, setpt}, {1'b1, 11'h0e6});
		freq <= 11'h40a;
		wait_gl(5'h01, `DSD_G_DASH, 16000);
		wait_gl(5'h00, 5'h03, 6000);
		decel <= 1'b1;
		bus_hi <= 1'b1;
		cycles(3);
		chk({dhold, dp_l, dp_r}, 3'b111);
		decel <= 1'b0;
		bus_hi <= 1'b0;
		done("run");
	endtask : t_run

	task t_stops;
		freq <= 11'h12c;
		run <= 1'b0;
		wait_gl(5'h03, 5'h00, 12000);
		freq <= 11'h0;
		wait_gl(`DSD_G_DASH, `DSD_G_DASH, 10);
		brake <= 1'b1;
		wait_gl(`DSD_G_B, `DSD_G_R, 10);
		brake <= 1'b0;
		wait_gl(`DSD_G_DASH, `DSD_G_DASH, 10);
		apb(1'b1, `DSD_CTRL_OFF, 32'h2);
		freq <= 11'h12c;
		run <= 1'b1;
		wait_gl(5'h03, 5'h00, 10);
		run <= 1'b0;
		wait_gl(`DSD_G_DASH, `DSD_G_DASH, 4);
		freq <= 11'h0;
		done("stops");
	endtask : t_stops

	task t_status;
		cur_lim <= 1'b1;
		wait_gl(`DSD_G_C, `DSD_G_L, 10);
		chk(ovl, 1'b0);
		cycles(60);
		chk(ovl, 1'b1);
		cur_lim <= 1'b0;
		evt(`DSD_EVT_INVALID);
		wait_gl(`DSD_G_E, `DSD_G_R, 10);
		apb(1'b1, `DSD_CTRL_OFF, 32'h40);
		evt(`DSD_EVT_OEM_EDIT);
		wait_gl(`DSD_G_G, `DSD_G_E, 10);
		apb(1'b1, `DSD_CTRL_OFF, 32'hc0);
		evt(`DSD_EVT_OEM_RESET);
		wait_gl(`DSD_G_G, `DSD_G_F, 10);
		apb(1'b1, `DSD_CTRL_OFF, 32'h180);
		// Show another message first, so the power-up check must repaint
		evt(`DSD_EVT_INVALID);
		wait_gl(`DSD_G_E, `DSD_G_R, 10);
		evt(`DSD_EVT_PWRUP);
		wait_gl(`DSD_G_G, `DSD_G_F, 10);
		rs_wait <= 1'b1;
		wait_gl(`DSD_G_S, `DSD_G_P, 3000);
		rs_wait <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			chk(inhibit, 1'b0);
			rs_fail <= 1'b1;
			cycles(1);
			rs_fail <= 1'b0;
			cycles(3);
		end
		wait_gl(`DSD_G_L, `DSD_G_C, 10);
		apb(1'b0, `DSD_STAT_OFF, 32'h0);
		chk({inhibit, rd[10]}, 2'b11);
		evt(`DSD_EVT_MANUAL);
		chk({inhibit, ovl}, 2'b00);
		evt(`DSD_EVT_FACTORY);
		chk(setpt, 11'h0c8);
		done("status");
	endtask : t_status

	task t_sources;
		apb(1'b1, `DSD_CTRL_OFF, 32'h2 << `DSD_CTRL_SRC_LSB);
		press(1'b1, 8);
		// The source code blinks, so allow for a whole dark half period
		wait_gl(src_l[2], src_r[2], 3000);
		chk(setpt, 11'h0c8);
		freq <= 11'h12c;
		run <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			apb(1'b1, `DSD_CTRL_OFF, ((i + 3) % 12) << `DSD_CTRL_SRC_LSB);
			wait_gl(src_l[(i + 3) % 12], src_r[(i + 3) % 12],
				3000);
		end
		done("sources");
	endtask : t_sources

	initial begin
		src_l = '{`DSD_G_C, `DSD_G_E, `DSD_G_E, `DSD_G_J, `DSD_G_O,
			`DSD_G_P, `DSD_G_P, `DSD_G_P, `DSD_G_P, `DSD_G_P, `DSD_G_P,
			`DSD_G_P};
		src_r = '{`DSD_G_P, `DSD_G_I, `DSD_G_U, `DSD_G_G, `DSD_G_P,
			5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07};
		{nrst, psel, penable, pwrite, want_up, want_dn} = 6'b0;
		{run, brake, decel, bus_hi, cur_lim, rs_fail, rs_wait} = 7'b0;
		{paddr, pwdata, freq} = '0;
		miscompares = 0;
		checks = 0;
		cyc = 0;
		cycles(16);
		nrst <= 1'b1;
		t_regs();
		t_stop_keys();
		t_run();
		t_stops();
		t_status();
		t_sources();
		print_verdict();
	end
endmodule : testbench
